/* include/eiep_pkg.sv */
// Constants for the extended interrupt enable and priority block
package eiep_pkg;

	// ----------------------------------------
	// Register addresses and reset values
	// ----------------------------------------
	localparam logic [7:0] EIEP_ADDR_ENABLE_TWO = 8'hE7;
	localparam logic [7:0] EIEP_ADDR_PRIORITY_TWO = 8'hF7;
	localparam logic [7:0] EIEP_RESET_BYTE = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int EIEP_BIT_TIMER5 = 7;
	localparam int EIEP_BIT_TIMER4 = 6;
	localparam int EIEP_BIT_CMP2 = 5;
	localparam int EIEP_BIT_PCA_B = 4;
	localparam int EIEP_BIT_UART_B = 3;
	localparam int EIEP_BIT_MATCH = 2;
	localparam int EIEP_BIT_CAN = 1;
	localparam int EIEP_BIT_REG_DROP = 0;
	localparam int EIEP_TIMER_CONTROL_REG_EXT_A_PEND = 1;
	localparam int EIEP_TIMER_CONTROL_REG_EXT_B_PEND = 3;
	localparam int EIEP_SRC_COUNT = 8;
	localparam int EIEP_PIN_COUNT = 8;
	localparam int EIEP_SEL_WIDTH = 3;

endpackage : eiep_pkg

/* rtl/eiep_ext_cond.sv */
// One external interrupt input: pin select, sync, polarity, edge or level
module eiep_ext_cond
	import eiep_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [EIEP_PIN_COUNT-1:0] port1_pins,
	input wire logic [EIEP_SEL_WIDTH-1:0] pin_select,
	input wire logic polarity,
	input wire logic edge_select,
	input wire logic vector_ack,
	output logic pending
);

	logic [EIEP_PIN_COUNT-1:0] meta_ff;
	logic [EIEP_PIN_COUNT-1:0] sync_ff;
	logic active_prev_ff;
	logic primed_ff;
	logic pending_ff;
	logic nxt_pending;
	wire logic active_now;
	wire logic active_rise;

	// ----------------------------------------
	// Pin synchroniser, input only
	// ----------------------------------------
	// All eight pins synced so reselecting never exposes a raw pin
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= port1_pins;
			sync_ff <= meta_ff;
		end
	end

	// Polarity 0 means pin low is active
	assign active_now = sync_ff[pin_select] ~^ polarity;
	// No edge in the first cycle after reset, so polarity 0 never fakes a rise; with polarity 1 a pin held high through reset still does
	assign active_rise = active_now & ~active_prev_ff & primed_ff;

	// ----------------------------------------
	// Pending flag
	// ----------------------------------------
	// A new edge in the vector cycle wins over the clear
	always_comb
	begin
		if (!edge_select)
			nxt_pending = active_now;
		else if (active_rise)
			nxt_pending = 1'b1;
		else if (vector_ack)
			nxt_pending = 1'b0;
		else
			nxt_pending = pending_ff;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			active_prev_ff <= 1'b0;
			primed_ff <= 1'b0;
			pending_ff <= 1'b0;
		end
		else
		begin
			active_prev_ff <= active_now;
			primed_ff <= 1'b1;
			pending_ff <= nxt_pending;
		end
	end

	assign pending = pending_ff;

endmodule : eiep_ext_cond

/* rtl/eiep_top.sv */
// Extended enable/priority two registers and external interrupt conditioning
module eiep_top
	import eiep_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic timer5_low_overflow_flag,
	input wire logic timer5_high_overflow_flag,
	input wire logic timer4_low_overflow_flag,
	input wire logic timer4_high_overflow_flag,
	input wire logic comparator2_rising_flag,
	input wire logic comparator2_falling_flag,
	input wire logic counter_array_b_irq,
	input wire logic uart_b_irq,
	input wire logic port_match_irq,
	input wire logic can_irq,
	input wire logic regulator_dropout_irq,
	input wire logic [EIEP_PIN_COUNT-1:0] port1_pins,
	input wire logic ext_a_edge_select,
	input wire logic ext_b_edge_select,
	input wire logic ext_a_polarity,
	input wire logic ext_b_polarity,
	input wire logic [EIEP_SEL_WIDTH-1:0] ext_a_pin_select,
	input wire logic [EIEP_SEL_WIDTH-1:0] ext_b_pin_select,
	input wire logic ext_a_vector_ack,
	input wire logic ext_b_vector_ack,
	output logic ext_a_pending,
	output logic ext_b_pending,
	output logic [7:0] timer_control_pend,
	output logic [EIEP_SRC_COUNT-1:0] irq_request_high,
	output logic [EIEP_SRC_COUNT-1:0] irq_request_low,
	output logic irq_any_high,
	output logic irq_any_low
);

	logic [7:0] extended_irq_enable_two_ff;
	logic [7:0] extended_irq_priority_two_ff;
	logic [7:0] sfr_rdata_ff;
	logic [EIEP_SRC_COUNT-1:0] req_high_ff;
	logic [EIEP_SRC_COUNT-1:0] req_low_ff;
	logic any_high_ff;
	logic any_low_ff;
	logic [7:0] nxt_rdata;
	wire logic ext_a_pend_w;
	wire logic ext_b_pend_w;
	wire logic sel_enable;
	wire logic sel_priority;
	wire logic [EIEP_SRC_COUNT-1:0] src_raw;
	wire logic [EIEP_SRC_COUNT-1:0] src_gated;
	wire logic [EIEP_SRC_COUNT-1:0] nxt_req_high;
	wire logic [EIEP_SRC_COUNT-1:0] nxt_req_low;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	assign sel_enable = (sfr_addr == EIEP_ADDR_ENABLE_TWO);
	assign sel_priority = (sfr_addr == EIEP_ADDR_PRIORITY_TWO);

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			extended_irq_enable_two_ff <= EIEP_RESET_BYTE;
			extended_irq_priority_two_ff <= EIEP_RESET_BYTE;
		end
		else if (sfr_wr)
		begin
			if (sel_enable)
				extended_irq_enable_two_ff <= sfr_wdata;
			if (sel_priority)
				extended_irq_priority_two_ff <= sfr_wdata;
		end
	end

	// Unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (sfr_rd && sel_enable)
			nxt_rdata = extended_irq_enable_two_ff;
		else if (sfr_rd && sel_priority)
			nxt_rdata = extended_irq_priority_two_ff;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			sfr_rdata_ff <= 8'h00;
		else
			sfr_rdata_ff <= nxt_rdata;
	end

	// ----------------------------------------
	// External interrupt conditioning
	// ----------------------------------------
	eiep_ext_cond u_ext_a (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.port1_pins(port1_pins),
		.pin_select(ext_a_pin_select),
		.polarity(ext_a_polarity),
		.edge_select(ext_a_edge_select),
		.vector_ack(ext_a_vector_ack),
		.pending(ext_a_pend_w)
	);

	eiep_ext_cond u_ext_b (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.port1_pins(port1_pins),
		.pin_select(ext_b_pin_select),
		.polarity(ext_b_polarity),
		.edge_select(ext_b_edge_select),
		.vector_ack(ext_b_vector_ack),
		.pending(ext_b_pend_w)
	);

	// ----------------------------------------
	// Source gating and priority split
	// ----------------------------------------
	// Either flag of a two-flag source raises the request
	assign src_raw[EIEP_BIT_TIMER5] =
		timer5_low_overflow_flag | timer5_high_overflow_flag;
	assign src_raw[EIEP_BIT_TIMER4] =
		timer4_low_overflow_flag | timer4_high_overflow_flag;
	assign src_raw[EIEP_BIT_CMP2] =
		comparator2_rising_flag | comparator2_falling_flag;
	assign src_raw[EIEP_BIT_PCA_B] = counter_array_b_irq;
	assign src_raw[EIEP_BIT_UART_B] = uart_b_irq;
	assign src_raw[EIEP_BIT_MATCH] = port_match_irq;
	assign src_raw[EIEP_BIT_CAN] = can_irq;
	assign src_raw[EIEP_BIT_REG_DROP] = regulator_dropout_irq;

	// Enable bit i masks source i, priority bit i picks its level
	genvar gi;
	generate
		for (gi = 0; gi < EIEP_SRC_COUNT; gi++)
		begin : g_src
			assign src_gated[gi] =
				src_raw[gi] & extended_irq_enable_two_ff[gi];
			assign nxt_req_high[gi] =
				src_gated[gi] & extended_irq_priority_two_ff[gi];
			assign nxt_req_low[gi] =
				src_gated[gi] & ~extended_irq_priority_two_ff[gi];
		end
	endgenerate

	// Priority bits 2..0 follow the same per-bit split

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			req_high_ff <= '0;
			req_low_ff <= '0;
			any_high_ff <= 1'b0;
			any_low_ff <= 1'b0;
		end
		else
		begin
			req_high_ff <= nxt_req_high;
			req_low_ff <= nxt_req_low;
			any_high_ff <= |nxt_req_high;
			// Low level is hidden while any high request stands
			any_low_ff <= (|nxt_req_low) & ~(|nxt_req_high);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sfr_rdata = sfr_rdata_ff;
	assign irq_request_high = req_high_ff;
	assign irq_request_low = req_low_ff;
	assign irq_any_high = any_high_ff;
	assign irq_any_low = any_low_ff;
	assign ext_a_pending = ext_a_pend_w;
	assign ext_b_pending = ext_b_pend_w;
	// Pending flags placed in their timer control bit slots
	assign timer_control_pend = {4'h0, ext_b_pend_w, 1'b0,
		ext_a_pend_w, 1'b0};

endmodule : eiep_top

/* bench/eiep_assertions.sv */
// Checker for request routing and external pending flags
module eiep_chk
	import eiep_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic timer5_low_overflow_flag,
	input wire logic timer5_high_overflow_flag,
	input wire logic [7:0] port1_pins,
	input wire logic ext_a_edge_select,
	input wire logic ext_a_polarity,
	input wire logic [2:0] ext_a_pin_select,
	input wire logic ext_a_vector_ack,
	input wire logic ext_a_pending,
	input wire logic ext_b_pending,
	input wire logic [7:0] timer_control_pend,
	input wire logic [7:0] irq_request_high,
	input wire logic [7:0] irq_request_low,
	input wire logic irq_any_high,
	input wire logic irq_any_low
);
	// --------
	// Properties
	// --------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	property p_pend;
		timer_control_pend == {4'h0, ext_b_pending, 1'h0, ext_a_pending, 1'h0};
	endproperty
	a_pend: assert property (p_pend) else $error("pend bits");
	property p_hi;
		irq_any_high == (|irq_request_high);
	endproperty
	a_hi: assert property (p_hi) else $error("any high");
	property p_lo;
		irq_any_low == (!(|irq_request_high) && (|irq_request_low));
	endproperty
	a_lo: assert property (p_lo) else $error("any low");
	property p_split;
		(irq_request_high & irq_request_low) == 8'h00;
	endproperty
	a_split: assert property (p_split) else $error("split");
	property p_t5;
		(irq_request_high[7] || irq_request_low[7]) |->
			$past(timer5_low_overflow_flag || timer5_high_overflow_flag);
	endproperty
	a_t5: assert property (p_t5) else $error("timer5 req");
	// Config held still, so the three-stage pin path is comparable
	property p_lvl;
		(!ext_a_edge_select && $stable(ext_a_polarity)
			&& $stable(ext_a_pin_select))[*4] |-> ext_a_pending ==
			($past(port1_pins[ext_a_pin_select], 3) ~^ ext_a_polarity);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level pend");
	property p_clr;
		(ext_a_edge_select && $stable(port1_pins))[*4] ##0 ext_a_vector_ack
			|=> !ext_a_pending;
	endproperty
	a_clr: assert property (p_clr) else $error("edge clear");
	property p_hold;
		ext_a_edge_select && ext_a_pending && !ext_a_vector_ack
			##1 ext_a_edge_select |-> ext_a_pending;
	endproperty
	a_hold: assert property (p_hold) else $error("edge hold");
endmodule : eiep_chk
bind eiep_top eiep_chk chk_u (.*);

/* bench/eiep_cpu_model.sv */
// Vectoring side model for one external interrupt input
module eiep_cpu_model
	import eiep_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic pending,
	input wire logic ack_en,
	output logic vector_ack
);
	// --------
	// Vector entry
	// --------
	// Single pulse: pending only drops on the edge after it
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			vector_ack <= 1'h0;
		else
			vector_ack <= pending && ack_en && !vector_ack;
	end
endmodule : eiep_cpu_model

/* bench/tb.sv */
// Bench for the enable/priority registers and external inputs
module tb
	import eiep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'h0, rstn = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
	logic ext_a_edge_select = 1'h0, ext_b_edge_select = 1'h0;
	logic ext_a_polarity = 1'h0, ext_b_polarity = 1'h0, ack_en = 1'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port1_pins = 8'h00;
	logic [2:0] ext_a_pin_select = 3'h0, ext_b_pin_select = 3'h0;
	logic [15:0] src = 16'h0000;
	logic [7:0] sfr_rdata, timer_control_pend;
	logic [7:0] irq_request_high, irq_request_low;
	logic ext_a_pending, ext_b_pending, ext_a_vector_ack, ext_b_vector_ack;
	logic irq_any_high, irq_any_low;
	int bad_count = 0, compares = 0;
	always #2.5 sys_clk = ~sys_clk;
	// --------
	// Design and vectoring partners
	// --------
	eiep_top dut_u (.*, .timer5_low_overflow_flag(src[15]),
		.timer5_high_overflow_flag(src[7]), .timer4_low_overflow_flag(src[6]),
		.timer4_high_overflow_flag(src[14]), .comparator2_rising_flag(src[13]),
		.comparator2_falling_flag(src[5]), .counter_array_b_irq(src[4]),
		.uart_b_irq(src[3]), .port_match_irq(src[2]), .can_irq(src[1]),
		.regulator_dropout_irq(src[0]));
	eiep_cpu_model cpu_a (.sys_clk, .rstn, .pending(ext_a_pending),
		.ack_en(ack_en), .vector_ack(ext_a_vector_ack));
	// Level mode ignores acks, so this one always answers
	eiep_cpu_model cpu_b (.sys_clk, .rstn, .pending(ext_b_pending),
		.ack_en(1'h1), .vector_ack(ext_b_vector_ack));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		tick(1);
		sfr_wr = 1'h0;
		sfr_rd = 1'h0;
		if (!w)
			chk("sfr_rdata", d, sfr_rdata);
	endtask : bus
	task t_regs;
		bus(1'h0, EIEP_ADDR_ENABLE_TWO, EIEP_RESET_BYTE);
		bus(1'h0, EIEP_ADDR_PRIORITY_TWO, EIEP_RESET_BYTE);
		bus(1'h1, EIEP_ADDR_PRIORITY_TWO, 8'hC3);
		bus(1'h1, 8'hE6, 8'hFF);
		bus(1'h0, EIEP_ADDR_PRIORITY_TWO, 8'hC3);
		bus(1'h0, 8'hE6, 8'h00);
		$display("regs test done");
	endtask : t_regs
	task t_route;
		int k, b;
		logic [7:0] m, pr;
		for (k = 0; k < 11; k++)
		begin
			b = (k < 8) ? k : k - 3;
			m = 8'h01 << b;
			pr = (k < 8) ? 8'hA5 : 8'h5A;
			bus(1'h1, EIEP_ADDR_ENABLE_TWO, m);
			bus(1'h1, EIEP_ADDR_PRIORITY_TWO, pr);
			src = 16'h0001 << ((k < 8) ? k : k + 5);
			tick(1);
			chk("req_high", pr & m, irq_request_high);
			chk("req_low", ~pr & m, irq_request_low);
			bus(1'h1, EIEP_ADDR_ENABLE_TWO, ~m);
			tick(1);
			chk("masked", 8'h00, irq_request_high | irq_request_low);
			src = 16'h0000;
		end
		bus(1'h1, EIEP_ADDR_ENABLE_TWO, 8'hFF);
		bus(1'h1, EIEP_ADDR_PRIORITY_TWO, 8'h01);
		src = 16'h0081;
		tick(1);
		chk("req_high", 8'h01, irq_request_high);
		chk("any", 8'h02, {6'h00, irq_any_high, irq_any_low});
		src = 16'h0000;
		$display("route test done");
	endtask : t_route
	task t_level;
		int p;
		ext_b_pin_select = 3'h7;
		for (p = 0; p < 2; p++)
		begin
			ext_b_polarity = p[0];
			port1_pins[7] = !p[0];
			tick(4);
			chk("pend_b", 8'h00, {7'h00, ext_b_pending});
			port1_pins[7] = p[0];
			tick(4);
			chk("timer_control_reg_b", 8'h08, timer_control_pend & 8'h08);
		end
		$display("level test done");
	endtask : t_level
	task t_edge;
		ext_a_edge_select = 1'h1;
		ext_a_polarity = 1'h1;
		ext_a_pin_select = 3'h2;
		ack_en = 1'h1;
		tick(4);
		ack_en = 1'h0;
		port1_pins = 8'h08;
		tick(4);
		chk("pend_a", 8'h00, {7'h00, ext_a_pending});
		port1_pins = 8'h0C;
		tick(4);
		chk("timer_control_reg", 8'h02, timer_control_pend);
		port1_pins = 8'h00;
		tick(4);
		chk("timer_control_reg", 8'h02, timer_control_pend);
		ack_en = 1'h1;
		tick(2);
		ack_en = 1'h0;
		chk("timer_control_reg", 8'h00, timer_control_pend);
		$display("edge test done");
	endtask : t_edge
	task complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	initial
	begin
		tick(16);
		rstn = 1'h1;
		t_regs();
		t_route();
		t_level();
		t_edge();
		complete_run();
	end
endmodule : tb
